// file: design/ebr_consts.vh
`ifndef EBR_CONSTS_VH
`define EBR_CONSTS_VH
// register byte addresses
`define EBR_ADDR_CARD5      8'h00
`define EBR_ADDR_CARD6      8'h04
`define EBR_ADDR_SDCTL      8'h08
`define EBR_ADDR_RTCS       8'h0C
`define EBR_ADDR_REFRESH_TIMER_COUNTER      8'h10
`define EBR_ADDR_RTCONST    8'h14
`define EBR_ADDR_IDLE       8'h18
// card timing fields
`define EBR_CARD_ATTR_HI    21
`define EBR_CARD_ATTR_LO    20
`define EBR_CARD_SETUP_MSB  14
`define EBR_CARD_SETUP_LSB  11
`define EBR_CARD_WAIT_MSB   10
`define EBR_CARD_WAIT_LSB   7
`define EBR_CARD_WMASK      6
`define EBR_CARD_HOLD_MSB   3
`define EBR_CARD_HOLD_LSB   0
`define EBR_CARD_MASK       32'h00307FCF
`define EBR_CARD_RESET      32'h00000500
// sdram control fields
`define EBR_SD_REFRESH_ENABLE         11
`define EBR_SD_REFRESH_KIND_SELECT        10
`define EBR_SD_BANK         8
`define EBR_SD_ROW_MSB      4
`define EBR_SD_ROW_LSB      3
`define EBR_SD_COL_MSB      1
`define EBR_SD_COL_LSB      0
`define EBR_SD_MASK         32'h00000D1B
`define EBR_SD_RESET        32'h00000000
// refresh timer control/status fields
`define EBR_RT_CMF          7
`define EBR_RT_CKS_MSB      5
`define EBR_RT_CKS_LSB      3
`define EBR_RT_RRC_MSB      2
`define EBR_RT_RRC_LSB      0
`define EBR_RT_KEY          16'hA55A
`define EBR_IDLE_RESET      2'h0
`endif

// file: design/ebr_refresh_cfg.v
`timescale 1ns/1ps
`include "ebr_consts.vh"
// Operation
// - idle after refresh: 2,3,5,8 cycles
// - address bit 25 picks attribute bit
// - strobe setup is field plus half
// - card wait code maps to table
// - wait-ignore bit masks external wait
// - address hold is field plus half
// - reserved bits read zero, written zero
// - bit 11 enables refreshing
// - mode bit selects self or auto
// - access-mode bit picks precharge style
// - row width 11,12,13 bits
// - column width 8,9,10 bits
// - timer control write needs upper key
// - flag set on counter match
// - flag cleared by zero after read
// - clock select divides or halts
// - refresh count per match 1..8
// - counter clears on match, wraps
// - pending request, newer replaces older
module ebr_refresh_cfg (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // card access context
  input  wire        card_a25_i,
  input  wire        card_area6_i,
  input  wire        ext_wait_i,
  output reg         card_io_space_o,
  output reg  [3:0]  card_setup_half_o,
  output reg  [6:0]  card_wait_cycles_o,
  output reg  [4:0]  card_hold_half_o,
  output reg         card_wait_active_o,
  // sdram side
  input  wire        refresh_done_i,
  input  wire        self_exit_i,
  output reg         refresh_req_o,
  output reg  [3:0]  refresh_burst_o,
  output reg         self_refresh_o,
  output reg         bank_open_mode_o,
  output reg  [3:0]  row_bits_o,
  output reg  [3:0]  col_bits_o,
  output reg         cmd_idle_block_o,
  output reg         cfg_prohibited_o
);

  reg  [31:0] card5_r;
  reg  [31:0] card6_r;
  reg  [31:0] sdctl_r;
  reg         cmf_r;
  reg  [2:0]  cks_r;
  reg  [2:0]  rrc_r;
  reg  [7:0]  refresh_timer_counter_r;
  reg  [7:0]  rtconst_r;
  reg  [1:0]  idle_sel_r;
  reg         cmf_seen_r;
  reg  [11:0] presc_r;
  reg  [3:0]  idle_cnt_r;
  reg         req_pend_r;

  wire        key_ok   = (wdata_i[31:16] == `EBR_RT_KEY);
  wire        rt_wr    = wr_i && (addr_i == `EBR_ADDR_RTCS) && key_ok;
  wire        cnt_wr   = wr_i && (addr_i == `EBR_ADDR_REFRESH_TIMER_COUNTER) && key_ok;
  wire        const_wr = wr_i && (addr_i == `EBR_ADDR_RTCONST) && key_ok;
  wire        refresh_on = sdctl_r[`EBR_SD_REFRESH_ENABLE];
  wire        tick;
  wire        match    = tick && (refresh_timer_counter_r == rtconst_r);
  wire [31:0] card_sel = card_area6_i ? card6_r : card5_r;

  // register strobes
  wire        card5_wr = wr_i && (addr_i == `EBR_ADDR_CARD5);
  wire        card6_wr = wr_i && (addr_i == `EBR_ADDR_CARD6);
  wire        sdctl_wr = wr_i && (addr_i == `EBR_ADDR_SDCTL);
  wire        idle_wr  = wr_i && (addr_i == `EBR_ADDR_IDLE);
  wire        rt_rd    = rd_i && (addr_i == `EBR_ADDR_RTCS);
  // a matching tick in the same cycle keeps the flag set
  wire        flag_clr = rt_wr && cmf_seen_r && !wdata_i[`EBR_RT_CMF] && !match;

  function [6:0] wait_map;
    input [3:0] c;
    begin
      case (c)
        4'h0:    wait_map = 7'd3;
        4'h1:    wait_map = 7'd6;
        4'h2:    wait_map = 7'd9;
        4'h3:    wait_map = 7'd12;
        4'h4:    wait_map = 7'd15;
        4'h5:    wait_map = 7'd18;
        4'h6:    wait_map = 7'd22;
        4'h7:    wait_map = 7'd26;
        4'h8:    wait_map = 7'd30;
        4'h9:    wait_map = 7'd33;
        4'hA:    wait_map = 7'd36;
        4'hB:    wait_map = 7'd38;
        4'hC:    wait_map = 7'd52;
        4'hD:    wait_map = 7'd60;
        4'hE:    wait_map = 7'd64;
        default: wait_map = 7'd80;
      endcase
    end
  endfunction

  function [11:0] div_mask;
    input [2:0] c;
    begin
      case (c)
        3'h1:    div_mask = 12'h003;
        3'h2:    div_mask = 12'h00F;
        3'h3:    div_mask = 12'h03F;
        3'h4:    div_mask = 12'h0FF;
        3'h5:    div_mask = 12'h3FF;
        3'h6:    div_mask = 12'h7FF;
        default: div_mask = 12'hFFF;
      endcase
    end
  endfunction

  function [3:0] idle_map;
    input [1:0] c;
    begin
      case (c)
        2'h0:    idle_map = 4'd2;
        2'h1:    idle_map = 4'd3;
        2'h2:    idle_map = 4'd5;
        default: idle_map = 4'd8;
      endcase
    end
  endfunction

  function [3:0] burst_map;
    input [2:0] c;
    begin
      case (c)
        3'h0:    burst_map = 4'd1;
        3'h1:    burst_map = 4'd2;
        3'h2:    burst_map = 4'd4;
        3'h3:    burst_map = 4'd6;
        default: burst_map = 4'd8;
      endcase
    end
  endfunction

  function [3:0] width_map;
    input [3:0] base;
    input [1:0] c;
    begin
      width_map = base + {2'b00, c};
    end
  endfunction

  function code_rsvd;
    input [1:0] c;
    begin
      code_rsvd = (c == 2'h3);
    end
  endfunction

  // prescaler: tick once per divided period, halt at code 0
  assign tick = (cks_r != 3'h0) && ((presc_r & div_mask(cks_r)) == div_mask(cks_r));

  // card space timing, one register per card area
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      card5_r <= `EBR_CARD_RESET;
    end else if (card5_wr) begin
      card5_r <= wdata_i & `EBR_CARD_MASK;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      card6_r <= `EBR_CARD_RESET;
    end else if (card6_wr) begin
      card6_r <= wdata_i & `EBR_CARD_MASK;
    end
  end

  // sdram control, reserved bits never stored
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sdctl_r <= `EBR_SD_RESET;
    end else if (sdctl_wr) begin
      sdctl_r <= wdata_i & `EBR_SD_MASK;
    end
  end

  // post-refresh idle count select
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_sel_r <= `EBR_IDLE_RESET;
    end else if (idle_wr) begin
      idle_sel_r <= wdata_i[1:0];
    end
  end

  // divider runs only while a clock is selected
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_r <= 12'h000;
    end else if (cks_r == 3'h0) begin
      presc_r <= 12'h000;
    end else begin
      presc_r <= presc_r + 12'h001;
    end
  end

  // clock select, key-protected
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cks_r <= 3'h0;
    end else if (rt_wr) begin
      cks_r <= wdata_i[`EBR_RT_CKS_MSB:`EBR_RT_CKS_LSB];
    end
  end

  // burst refresh count, key-protected
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rrc_r <= 3'h0;
    end else if (rt_wr) begin
      rrc_r <= wdata_i[`EBR_RT_RRC_MSB:`EBR_RT_RRC_LSB];
    end
  end

  // a read with the flag high arms the clear
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmf_seen_r <= 1'b0;
    end else if (rt_rd && cmf_r) begin
      cmf_seen_r <= 1'b1;
    end else if (flag_clr) begin
      cmf_seen_r <= 1'b0;
    end
  end

  // flag: set wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmf_r <= 1'b0;
    end else if (match) begin
      cmf_r <= 1'b1;
    end else if (flag_clr) begin
      cmf_r <= 1'b0;
    end
  end

  // counter: software load, then match clear, then count
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      refresh_timer_counter_r <= 8'h00;
    end else if (cnt_wr) begin
      refresh_timer_counter_r <= wdata_i[7:0];
    end else if (match) begin
      refresh_timer_counter_r <= 8'h00;
    end else if (tick) begin
      refresh_timer_counter_r <= refresh_timer_counter_r + 8'h01;
    end
  end

  // time constant, key-protected
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rtconst_r <= 8'h00;
    end else if (const_wr) begin
      rtconst_r <= wdata_i[7:0];
    end
  end

  // one pending request; a new match overwrites it
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_pend_r <= 1'b0;
    end else if (!refresh_on || sdctl_r[`EBR_SD_REFRESH_KIND_SELECT]) begin
      req_pend_r <= 1'b0;
    end else if (match) begin
      req_pend_r <= 1'b1;
    end else if (refresh_done_i) begin
      req_pend_r <= 1'b0;
    end
  end

  // idle countdown, reloaded by each refresh or self-refresh exit
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_cnt_r <= 4'h0;
    end else if (refresh_done_i || self_exit_i) begin
      idle_cnt_r <= idle_map(idle_sel_r);
    end else if (idle_cnt_r != 4'h0) begin
      idle_cnt_r <= idle_cnt_r - 4'h1;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `EBR_ADDR_CARD5:   rdata_o <= card5_r;
          `EBR_ADDR_CARD6:   rdata_o <= card6_r;
          `EBR_ADDR_SDCTL:   rdata_o <= sdctl_r;
          `EBR_ADDR_RTCS:    rdata_o <= {24'h000000, cmf_r, 1'b0, cks_r, rrc_r};
          `EBR_ADDR_REFRESH_TIMER_COUNTER:   rdata_o <= {24'h000000, refresh_timer_counter_r};
          `EBR_ADDR_RTCONST: rdata_o <= {24'h000000, rtconst_r};
          `EBR_ADDR_IDLE:    rdata_o <= {30'h00000000, idle_sel_r};
          default:           rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // card access decode, follows the selected area each cycle
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      card_io_space_o    <= 1'b0;
      card_setup_half_o  <= 4'h0;
      card_wait_cycles_o <= 7'd3;
      card_hold_half_o   <= 5'h00;
      card_wait_active_o <= 1'b0;
    end else begin
      card_io_space_o <= card_a25_i ? card_sel[`EBR_CARD_ATTR_HI]
                                    : card_sel[`EBR_CARD_ATTR_LO];
      // setup field alone; the half cycle is implied
      card_setup_half_o <= {1'b0, card_sel[`EBR_CARD_SETUP_LSB+2:`EBR_CARD_SETUP_LSB]};
      card_wait_cycles_o <= wait_map(card_sel[`EBR_CARD_WAIT_MSB:`EBR_CARD_WAIT_LSB]);
      // hold in half cycles: 2*field+1
      card_hold_half_o <= {card_sel[`EBR_CARD_HOLD_MSB:`EBR_CARD_HOLD_LSB], 1'b1};
      card_wait_active_o <= ext_wait_i && !card_sel[`EBR_CARD_WMASK];
    end
  end

  // refresh side outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      refresh_req_o   <= 1'b0;
      refresh_burst_o <= 4'h1;
      self_refresh_o  <= 1'b0;
    end else begin
      refresh_req_o   <= req_pend_r;
      refresh_burst_o <= burst_map(rrc_r);
      self_refresh_o  <= refresh_on && sdctl_r[`EBR_SD_REFRESH_KIND_SELECT];
    end
  end

  // sdram geometry and access style
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      bank_open_mode_o <= 1'b0;
      row_bits_o       <= 4'd11;
      col_bits_o       <= 4'd8;
    end else begin
      bank_open_mode_o <= sdctl_r[`EBR_SD_BANK];
      row_bits_o <= width_map(4'd11, sdctl_r[`EBR_SD_ROW_MSB:`EBR_SD_ROW_LSB]);
      col_bits_o <= width_map(4'd8, sdctl_r[`EBR_SD_COL_MSB:`EBR_SD_COL_LSB]);
    end
  end

  // command blocking while the idle count runs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_idle_block_o <= 1'b0;
    end else begin
      cmd_idle_block_o <= (idle_cnt_r > 4'h1) || refresh_done_i || self_exit_i;
    end
  end

  // prohibited-code status
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_prohibited_o <= 1'b0;
    end else begin
      cfg_prohibited_o <= code_rsvd(sdctl_r[`EBR_SD_ROW_MSB:`EBR_SD_ROW_LSB]) ||
                          code_rsvd(sdctl_r[`EBR_SD_COL_MSB:`EBR_SD_COL_LSB]) ||
                          card_sel[`EBR_CARD_SETUP_MSB] || (rrc_r > 3'h4);
    end
  end

endmodule

// file: verification/ebr_refresh_cfg_assertions.sv
`timescale 1ns/1ps
`include "ebr_consts.vh"
module ebr_chk (
  input wire        clk_i,
  input wire        rst_n_i,
  input wire [7:0]  addr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        ext_wait_i,
  input wire        card_wait_active_o,
  input wire [6:0]  card_wait_cycles_o,
  input wire [3:0]  card_setup_half_o,
  input wire        refresh_done_i,
  input wire        refresh_req_o,
  input wire [3:0]  refresh_burst_o,
  input wire [3:0]  row_bits_o,
  input wire [3:0]  col_bits_o,
  input wire        cfg_prohibited_o,
  input wire        cmd_idle_block_o,
  input wire        self_refresh_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_sd_reserved: assert property (
    $past(rd_i) && $past(addr_i) == `EBR_ADDR_SDCTL |-> (rdata_o & ~`EBR_SD_MASK) == 32'h0)
    else $error("sdram ctl reserved bits set");
  chk_rt_reserved: assert property (
    $past(rd_i) && $past(addr_i) == `EBR_ADDR_RTCS |-> (rdata_o & 32'hFFFFFF40) == 32'h0)
    else $error("timer ctl reserved bits set");
  chk_idle_start: assert property (
    refresh_done_i |-> ##[1:2] cmd_idle_block_o) else $error("no idle block after refresh");
  chk_wait_mask: assert property (
    card_wait_active_o |-> $past(ext_wait_i)) else $error("wait active without input");
  chk_wait_table: assert property (
    card_wait_cycles_o inside {3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80})
    else $error("wait count off table");
  chk_burst_set: assert property (
    refresh_burst_o inside {1, 2, 4, 6, 8}) else $error("burst count off table");
  chk_row_col: assert property (
    cfg_prohibited_o || (row_bits_o inside {11, 12, 13} && col_bits_o inside {8, 9, 10}))
    else $error("row or column width off table");
  chk_setup_range: assert property (
    card_setup_half_o < 4'h8) else $error("setup above range");
  chk_req_clear: assert property (
    refresh_req_o && refresh_done_i |-> ##[1:2] !refresh_req_o) else $error("request stuck");
  cover property ($rose(refresh_req_o));
  cover property ($rose(self_refresh_o));
  cover property (cfg_prohibited_o);
endmodule
bind ebr_refresh_cfg ebr_chk u_chk (.*);

// file: verification/ebr_sdram_model.sv
`timescale 1ns/1ps
module ebr_sdram_model (
  input  wire  clk_i,
  input  wire  rst_n_i,
  input  wire  refresh_req_i,
  input  wire  self_refresh_i,
  output logic refresh_done_o = 1'b0,
  output logic self_exit_o    = 1'b0
);
  logic self_d = 1'b0;
  int   dly;
  // self refresh left when the mode drops
  always @(posedge clk_i) begin
    self_exit_o <= rst_n_i && self_d && !self_refresh_i;
    self_d      <= rst_n_i && self_refresh_i;
  end
  // serve pending requests, promptly or slowly
  initial forever begin
    @(posedge clk_i);
    if (refresh_req_i === 1'b1) begin
      dly = 1 + $urandom % 6;
      repeat (dly) @(posedge clk_i);
      refresh_done_o <= 1'b1;
      @(posedge clk_i);
      refresh_done_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "ebr_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  logic        clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  logic        card_a25_i = 0, card_area6_i = 0, ext_wait_i = 0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, v, q;
  wire  [31:0] rdata_o;
  wire         card_io_space_o, card_wait_active_o, refresh_done_i, self_exit_i;
  wire         refresh_req_o, self_refresh_o, bank_open_mode_o, cmd_idle_block_o;
  wire         cfg_prohibited_o;
  wire  [3:0]  card_setup_half_o, refresh_burst_o, row_bits_o, col_bits_o;
  wire  [6:0]  card_wait_cycles_o;
  wire  [4:0]  card_hold_half_o;
  logic [31:0] exp_q[$];
  logic [6:0]  wtab[16] = '{3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80};
  logic [3:0]  btab[5] = '{1, 2, 4, 6, 8};
  int          num_errors = 0, n_compared = 0, idle_run = 0, i, j, n;
  ebr_refresh_cfg uut (.*);
  ebr_sdram_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .refresh_req_i(refresh_req_o),
    .self_refresh_i(self_refresh_o), .refresh_done_o(refresh_done_i), .self_exit_o(self_exit_i));
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rd_d       <= rd_i;
    ext_wait_i <= 1'($urandom);
  end
  always @(negedge clk_i) if (rd_d) begin
    q = exp_q.pop_front();
    `CHK(rdata_o, q)
  end
  always @(posedge clk_i) begin
    if (cmd_idle_block_o === 1'b1) idle_run <= idle_run + 1;
    else if (idle_run != 0) begin
      `CHK(idle_run, 8)
      idle_run <= 0;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wait_rise(output int c);
    c = 0;
    while (refresh_req_o !== 1'b0 && c < 2000) begin @(posedge clk_i); c++; end
    while (refresh_req_o !== 1'b1 && c < 2000) begin @(posedge clk_i); c++; end
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #5000000;
    num_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(43155));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'(4 * i), (i < 2) ? `EBR_CARD_RESET : 32'h0);
    `CHK(row_bits_o, 4'hB)
    `CHK(col_bits_o, 4'h8)
    wr(`EBR_ADDR_IDLE, 32'h3);
    rd(`EBR_ADDR_IDLE, 32'h3);
    for (i = 0; i < 16; i++) begin
      v = $urandom & `EBR_CARD_MASK & 32'hFFFFBFFF;
      v[10:7] = 4'(i);
      card_area6_i <= i[0];
      card_a25_i <= 1'($urandom);
      wr(i[0] ? `EBR_ADDR_CARD6 : `EBR_ADDR_CARD5, v);
      #210;
      `CHK(card_wait_cycles_o, wtab[i])
      `CHK(card_setup_half_o, {1'b0, v[13:11]})
      `CHK(card_hold_half_o, {v[3:0], 1'b1})
      `CHK(card_io_space_o, card_a25_i ? v[21] : v[20])
      rd(i[0] ? `EBR_ADDR_CARD6 : `EBR_ADDR_CARD5, v);
    end
    wr(`EBR_ADDR_CARD6, 32'h4500);
    #210;
    `CHK(cfg_prohibited_o, 1'b1)
    wr(`EBR_ADDR_CARD6, 32'h500);
    for (i = 0; i < 3; i++) for (j = 0; j < 3; j++) begin
      v = (i << 3) | j | (((i + j) & 1) << 8);
      wr(`EBR_ADDR_SDCTL, v);
      #210;
      `CHK(row_bits_o, 4'(11 + i))
      `CHK(col_bits_o, 4'(8 + j))
      `CHK(bank_open_mode_o, v[8])
      `CHK(cfg_prohibited_o, 1'b0)
    end
    wr(`EBR_ADDR_SDCTL, 32'h3);
    #210;
    `CHK(cfg_prohibited_o, 1'b1)
    wr(`EBR_ADDR_SDCTL, 32'h0);
    wr(`EBR_ADDR_RTCONST, 32'hA55A0003);
    wr(`EBR_ADDR_RTCS, 32'h3C);
    rd(`EBR_ADDR_RTCS, 32'h0);
    for (i = 0; i < 5; i++) begin
      wr(`EBR_ADDR_RTCS, 32'hA55A0008 | i);
      #210;
      `CHK(refresh_burst_o, btab[i])
    end
    for (n = 0; n < 40; n++) begin @(posedge clk_i); #10; `CHK(refresh_req_o, 1'b0) end
    rd(`EBR_ADDR_RTCS, 32'h8C);
    wr(`EBR_ADDR_RTCS, 32'hA55A0084);
    wr(`EBR_ADDR_RTCS, 32'hA55A0004);
    rd(`EBR_ADDR_RTCS, 32'h4);
    wr(`EBR_ADDR_SDCTL, 32'h800);
    for (i = 1; i < 4; i++) begin
      wr(`EBR_ADDR_RTCS, 32'hA55A0000 | (i << 3));
      wait_rise(n);
      wait_rise(n);
      `CHK(n, 4 << (2 * i))
    end
    wr(`EBR_ADDR_SDCTL, 32'hC00);
    #210;
    `CHK(self_refresh_o, 1'b1)
    repeat (40) @(posedge clk_i);
    `CHK(refresh_req_o, 1'b0)
    wr(`EBR_ADDR_SDCTL, 32'h0);
    #210;
    `CHK(self_refresh_o, 1'b0)
    repeat (20) @(posedge clk_i);
    wrap_up;
  end
endmodule
